// ===== bench/ccd_sink.sv
/*
 Far-side model: a free-running external clock source and a device
 that times the clock output. Assumes core_clk at 20 MHz.
*/
`timescale 1ns/1ps
`default_nettype none

module ccd_sink (
	input  wire logic core_clk, // Core clock
	input  wire logic co_pin,   // Clock output level
	input  wire logic co_oe,    // Clock output drive
	input  wire logic cpu_en,   // CPU clock pulse
	output logic      ext_clk,  // External clock, core over six
	output int        co_per    // CPU clocks per output period
);
	int   cnt;
	logic last;
	logic lv;

	// Oscillator runs free, so it never stops between uses
	initial begin
		ext_clk = 1'b0;
		#17;
		forever #150 ext_clk = ~ext_clk;
	end

	// Undriven pin reads low here, as if pulled down
	assign lv = co_oe & co_pin;

	// Count CPU clocks between rises of the output
	initial begin
		co_per = 0;
		cnt = 0;
		last = 1'b0;
		forever begin
			@(negedge core_clk);
			if (lv && !last) begin
				co_per = cnt;
				cnt = 0;
			end
			if (cpu_en === 1'b1) cnt++;
			last = lv;
		end
	end
endmodule : ccd_sink

`default_nettype wire

// ===== bench/ccd_top_tb.sv
/*
 Bench for the CPU clock block: ratios, duty, pins, clock output
 and wake count. Assumes ccd_sink as the far side.
*/
`timescale 1ns/1ps
`default_nettype none

module ccd_top_tb;
	import ccd_pkg::*;
	logic core_clk, sys_rst, hv, div_wr, xin, pd_req, wake;
	logic en, ck, co, coe, p20, p21, ex;
	logic [7:0] wd, pm, dv;
	logic [15:0] sq[$], eq[$];
	logic [31:0] seed;
	ccd_osc_e src;
	int err_count, num_checks, per, i, p;

	ccd_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.osc_sel_strap(src), .compat_clock_halve(hv), .div_wr(div_wr),
		.div_wdata(wd), .port2_mode_one(pm), .ext_clock_in_pin(xin),
		.pd_req(pd_req), .wake(wake), .cpu_clock_divider(dv),
		.cpu_clk_en(en), .cpu_clk(ck), .clock_out_pin_o(co),
		.clock_out_pin_oe(coe), .p20_port_en(p20), .p21_port_en(p21),
		.exec_en(ex));
	ccd_sink u_sink (.core_clk(core_clk), .co_pin(co), .co_oe(coe),
		.cpu_en(en), .ext_clk(xin), .co_per(per));

	// ---------------------------------------------------------
	// Checking and reporting
	// ---------------------------------------------------------
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task automatic post(input logic [15:0] s, input logic [15:0] e);
		sq.push_back(s);
		eq.push_back(e);
	endtask : post

	task automatic give_verdict;
		while (sq.size() > 0) chk(sq.pop_front(), eq.pop_front());
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict

	task automatic fail_to;
		err_count++;
		give_verdict();
	endtask : fail_to

	// Watcher checks all queued notes, oldest first, at each rising edge
	initial forever begin
		@(posedge core_clk);
		while (sq.size() > 0) chk(sq.pop_front(), eq.pop_front());
	end

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// ---------------------------------------------------------
	// Drivers, all at the falling edge
	// ---------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction : xs

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// Strap is only looked at in reset, so change it there
	task automatic rst(input ccd_osc_e s, input logic h);
		src = s;
		hv = h;
		sys_rst = 1'b1;
		pm = 8'h00;
		cyc(5);
		sys_rst = 1'b0;
		cyc(1);
		post({8'h00, dv}, 16'h0000);
		post({15'h0, ex}, 16'h0001);
	endtask : rst

	task automatic wdiv(input logic [7:0] n);
		div_wr = 1'b1;
		wd = n;
		cyc(1);
		div_wr = 1'b0;
		cyc(1);
		post({8'h00, dv}, {8'h00, n});
	endtask : wdiv

	// Core cycles up to the next CPU clock pulse, bounded
	task automatic wen(output int q);
		q = 0;
		do begin
			cyc(1);
			q++;
		end while (en !== 1'b1 && q < 3000);
		if (q >= 3000) fail_to();
	endtask : wen

	// First two pulses may still close old-ratio or ratio-1 periods
	task automatic tr(input logic [7:0] n, input logic h);
		int q, r;
		r = (n == 8'h00) ? 1 : 2 * (int'(n) + 1);
		if (h) r = r * 2;
		wdiv(n);
		wen(q);
		wen(q);
		wen(q);
		post(q[15:0], r[15:0]);
	endtask : tr

	task automatic pdn(input int w);
		int c, q;
		pd_req = 1'b1;
		cyc(1);
		pd_req = 1'b0;
		post({15'h0, ex}, 16'h0000);
		// A pulse launched on the entry edge still drains out
		cyc(1);
		c = 0;
		repeat (20) begin
			cyc(1);
			if (en === 1'b1) c++;
		end
		post(c[15:0], 16'h0000);
		post({15'h0, coe}, 16'h0000);
		wake = 1'b1;
		cyc(1);
		wake = 1'b0;
		c = 0;
		q = 0;
		do begin
			cyc(1);
			q++;
			// Last warm pulse lands together with exec_en
			if (en === 1'b1) c++;
		end while (ex !== 1'b1 && q < 20000);
		if (q >= 20000) fail_to();
		post(c[15:0], w[15:0]);
	endtask : pdn

	// ---------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		div_wr = 1'b0;
		wd = 8'h00;
		pm = 8'h00;
		pd_req = 1'b0;
		wake = 1'b0;
		hv = 1'b0;
		src = CCD_OSC_HIGH;
		seed = 32'd32;
		err_count = 0;
		num_checks = 0;
		// Crystal ratios: zero, edges of range, random
		rst(CCD_OSC_HIGH, 1'b0);
		tr(8'h00, 1'b0);
		tr(8'h01, 1'b0);
		tr(8'hff, 1'b0);
		for (i = 0; i < 3; i++) begin
			seed = xs(seed);
			tr(seed[7:0], 1'b0);
		end
		tr(8'h02, 1'b0);
		wen(p);
		p = 0;
		while (ck === 1'b1 && p < 600) begin
			p++;
			cyc(1);
		end
		post(p[15:0], 16'd3);
		// Back-to-back writes, last one wins
		div_wr = 1'b1;
		wd = 8'h05;
		cyc(1);
		wd = 8'h02;
		cyc(1);
		div_wr = 1'b0;
		cyc(1);
		post({8'h00, dv}, 16'h0002);
		wen(p);
		wen(p);
		wen(p);
		post(p[15:0], 16'd6);
		rst(CCD_OSC_HIGH, 1'b1);
		tr(8'h00, 1'b1);
		tr(8'h03, 1'b1);
		pdn(1024);
		// Pin use for every source, output on and off
		for (i = 0; i < 5; i++) begin
			rst(ccd_osc_e'(i[2:0]), 1'b0);
			pm = 8'h10;
			cyc(2);
			post({15'h0, coe}, {15'h0, i >= 3});
			post({14'h0, p21, p20}, {14'h0, i == 3, 1'b0});
			pm = 8'h00;
			cyc(2);
			post({14'h0, p21, p20}, {14'h0, i == 3, i >= 3});
		end
		// External clock at core over six, ratio four
		wdiv(8'h01);
		wen(p);
		wen(p);
		wen(p);
		post(p[15:0], 16'd24);
		// RC rate, output period, strap ignored after reset
		rst(CCD_OSC_RC, 1'b0);
		pm = 8'h10;
		src = CCD_OSC_LOW;
		p = 0;
		repeat (200) begin
			cyc(1);
			if (en === 1'b1) p++;
		end
		post(p[15:0], 16'd60);
		post(per[15:0], 16'd6);
		post({15'h0, coe}, 16'h0001);
		pdn(256);
		cyc(2);
		post({15'h0, coe}, 16'h0001);
		// Software drops the output before Idle when unneeded
		pm = 8'h00;
		cyc(2);
		post({14'h0, coe, co}, 16'h0000);
		post({15'h0, p20}, 16'h0001);
		give_verdict();
	end
endmodule : ccd_top_tb

`default_nettype wire

// ===== inc/ccd_map.svh
/*
 Timing counts, field positions and reset values for the CPU clock
 divider and clock output block. Assumes a 20 MHz core_clk.
*/
//
// Summary of operation
// R01 - Oscillator source fixed by programmed configuration
// R02 - RC source runs at nominal 6 MHz
// R03 - External clock frees second oscillator pin
// R04 - Clock output only with RC or external
// R05 - Clock output runs whenever oscillator runs
// R06 - Clock output is CPU clock over six
// R07 - Software clears enable before Idle if unneeded
// R08 - Compatibility halving divides CPU clock by two
// R09 - Halving slows peripherals as well
// R10 - Divider resets zero, zero means undivided
// R11 - Divider N gives ratio two times N+1
// R12 - Divider writable any time without stall
// R13 - Crystal source disables both oscillator pins
// R14 - Clock output enable is mode bit four
// R15 - Wake waits 1024 or 256 CPU clocks
// R16 - New ratio taken only on period boundary
// R17 - Even ratios give fifty percent duty
`ifndef CCD_MAP_SVH
`define CCD_MAP_SVH

// ----------------------------------------------------------------
// Rates and counts
// ----------------------------------------------------------------
`define CCD_CORE_KHZ    15'd20000
`define CCD_RC_KHZ      15'd6000
`define CCD_WARM_XTAL   11'd1024
`define CCD_WARM_RC     11'd256
`define CCD_CO_LAST     2'd2

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define CCD_CLOCK_OUT_ENABLE_BIT   4
`define CCD_DIV_RST     8'h00

`endif

// ===== inc/ccd_pkg.sv
/*
 Types shared by the clock divider block: oscillator source codes and
 the power state machine. Assumes ccd_map.svh for numeric constants.
*/
package ccd_pkg;

	// Oscillator source as programmed into the configuration byte
	typedef enum logic [2:0] {
		CCD_OSC_LOW  = 3'h0,
		CCD_OSC_MED  = 3'h1,
		CCD_OSC_HIGH = 3'h2,
		CCD_OSC_RC   = 3'h3,
		CCD_OSC_EXT  = 3'h4
	} ccd_osc_e;

	// Oscillator power states, Gray coded along run-stop-warm
	typedef enum logic [1:0] {
		CCD_RUN  = 2'b00,
		CCD_STOP = 2'b01,
		CCD_WARM = 2'b11
	} ccd_pwr_e;

endpackage : ccd_pkg

// ===== src/ccd_div.sv
/*
 Programmable divider: turns oscillator ticks into a CPU clock enable
 and a clock level. Assumes tick is a one-cycle pulse on core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module ccd_div (
	input  wire logic       core_clk, // Core clock
	input  wire logic       sys_rst,  // Sync reset, high
	input  wire logic       tick,     // Oscillator tick
	input  wire logic [9:0] half_len, // Ticks per half, 0 = ratio 1
	output logic            cpu_en,   // CPU clock enable pulse
	output logic            cpu_lvl   // CPU clock level
);

	logic [9:0] cur;
	logic [9:0] cnt;
	wire        last     = (cnt == cur - 10'd1);
	wire        boundary = tick && ((cur == 10'd0) || (last && !cpu_lvl));

	// ------------------------------------------------------------
	// Half-period counter
	// ------------------------------------------------------------
	// Ratio is loaded at the rising edge, or at any tick while undivided, so no runt period
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cur     <= 10'd0;
			cnt     <= 10'd0;
			cpu_en  <= 1'b0;
			cpu_lvl <= 1'b0;
		end else begin
			cpu_en <= boundary;
			if (boundary) begin
				cur     <= half_len; // R16
				cnt     <= 10'd0;
				cpu_lvl <= ~cpu_lvl;
			end else if (tick && last) begin
				cnt     <= 10'd0;
				cpu_lvl <= ~cpu_lvl; // R17
			end else if (tick) begin
				cnt <= cnt + 10'd1;
			end
		end
	end

endmodule : ccd_div

`default_nettype wire

// ===== src/ccd_top.sv
/*
 CPU clock generation: oscillator source, compatibility halving,
 programmable divider, clock output pin and wake-up warm count.
 Assumes the crystal oscillator is core_clk itself and that the
 configuration strap is stable while sys_rst is high.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ccd_map.svh"

module ccd_top (
	input  wire logic            core_clk,        // 20 MHz clock
	input  wire logic            sys_rst,         // Sync reset, high
	input  wire ccd_pkg::ccd_osc_e osc_sel_strap, // Programmed source
	input  wire logic            compat_clock_halve, // Config halving
	input  wire logic            div_wr,          // Divider write
	input  wire logic [7:0]      div_wdata,       // Divider data
	input  wire logic [7:0]      port2_mode_one,  // Port 2 mode reg
	input  wire logic            ext_clock_in_pin, // External clock
	input  wire logic            pd_req,          // Enter power-down
	input  wire logic            wake,            // Wake event
	output logic [7:0]           cpu_clock_divider, // Divider value
	output logic                 cpu_clk_en,      // CPU+periph enable
	output logic                 cpu_clk,         // CPU clock level
	output logic                 clock_out_pin_o, // Clock out level
	output logic                 clock_out_pin_oe, // Clock out drive
	output logic                 p20_port_en,     // Second pin as GPIO
	output logic                 p21_port_en,     // First pin as GPIO
	output logic                 exec_en          // Execution allowed
);
	import ccd_pkg::*;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Ticks per half CPU period; 0 codes the undivided ratio
	function automatic logic [9:0] ccd_half(input logic [7:0] n,
	                                        input logic       h);
		logic [9:0] base;
		base = {2'b00, n} + 10'd1;
		if (n == 8'h00)
			ccd_half = h ? 10'd1 : 10'd0;
		else if (h)
			ccd_half = {base[8:0], 1'b0};
		else
			ccd_half = base;
	endfunction : ccd_half

	function automatic logic ccd_is_xtal(input ccd_osc_e s);
		ccd_is_xtal = (s == CCD_OSC_LOW) || (s == CCD_OSC_MED) ||
		              (s == CCD_OSC_HIGH);
	endfunction : ccd_is_xtal

	// ------------------------------------------------------------
	// Configuration capture
	// ------------------------------------------------------------
	ccd_osc_e   src;
	logic       halve;

	// Caught only during reset, never changed by running code
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			src   <= osc_sel_strap; // R01
			halve <= compat_clock_halve;
		end
	end

	wire src_xtal   = ccd_is_xtal(src);
	wire src_rc_ext = (src == CCD_OSC_RC) || (src == CCD_OSC_EXT);

	// ------------------------------------------------------------
	// Divider register
	// ------------------------------------------------------------
	// Writes land any cycle; the divider picks them up at its edge
	always_ff @(posedge core_clk) begin
		if (sys_rst)
			cpu_clock_divider <= `CCD_DIV_RST; // R10
		else if (div_wr)
			cpu_clock_divider <= div_wdata; // R12
	end

	// ------------------------------------------------------------
	// External clock synchroniser
	// ------------------------------------------------------------
	logic ext_s1;
	logic ext_s2;
	logic ext_s3;
	logic ext_lvl;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ext_s1  <= 1'b0;
			ext_s2  <= 1'b0;
			ext_s3  <= 1'b0;
			ext_lvl <= 1'b0;
		end else begin
			ext_s1 <= ext_clock_in_pin;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			if (ext_s2 == ext_s3)
				ext_lvl <= ext_s3;
		end
	end

	// Rising edge counts once two stages agree; limits rate to fclk/4
	wire ext_tick = (ext_s2 == ext_s3) && ext_s3 && !ext_lvl;

	// ------------------------------------------------------------
	// RC oscillator model
	// ------------------------------------------------------------
	// Fractional accumulator; average 6 MHz, jitter of one core cycle
	logic [14:0] rc_acc;
	wire  [15:0] rc_sum  = {1'b0, rc_acc} + {1'b0, `CCD_RC_KHZ};
	wire         rc_wrap = (rc_sum >= {1'b0, `CCD_CORE_KHZ});
	wire  [15:0] rc_next = rc_wrap ? rc_sum - {1'b0, `CCD_CORE_KHZ}
	                               : rc_sum;

	always_ff @(posedge core_clk) begin
		if (sys_rst)
			rc_acc <= 15'd0;
		else
			rc_acc <= rc_next[14:0]; // R02
	end

	// ------------------------------------------------------------
	// Oscillator power states
	// ------------------------------------------------------------
	ccd_pwr_e    pwr;
	ccd_pwr_e    next_pwr;
	logic [10:0] warm_cnt;
	logic        cpu_en_w;
	logic        cpu_lvl_w;

	wire [10:0] warm_need = src_xtal ? `CCD_WARM_XTAL : `CCD_WARM_RC;
	wire        warm_done = cpu_en_w && (warm_cnt == warm_need - 11'd1);
	wire        osc_on    = (pwr != CCD_STOP);

	// Next state
	always_comb begin
		next_pwr = pwr;
		case (pwr)
			CCD_RUN:  if (pd_req) next_pwr = CCD_STOP;
			CCD_STOP: if (wake) next_pwr = CCD_WARM;
			CCD_WARM: if (warm_done) next_pwr = CCD_RUN; // R15
			default:  next_pwr = CCD_RUN;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pwr      <= CCD_RUN;
			warm_cnt <= 11'd0;
		end else begin
			pwr <= next_pwr;
			if (pwr != CCD_WARM)
				warm_cnt <= 11'd0;
			else if (cpu_en_w)
				warm_cnt <= warm_cnt + 11'd1; // R15
		end
	end

	// ------------------------------------------------------------
	// Tick select and divider
	// ------------------------------------------------------------
	wire src_tick = (src == CCD_OSC_EXT) ? ext_tick :
	                (src == CCD_OSC_RC)  ? rc_wrap  : 1'b1;
	wire osc_tick = osc_on && src_tick;
	// Halving is folded into the ratio, so peripherals see it too
	wire [9:0] half_len = ccd_half(cpu_clock_divider, halve); // R08 R11

	ccd_div u_div (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.tick     (osc_tick),
		.half_len (half_len),
		.cpu_en   (cpu_en_w),
		.cpu_lvl  (cpu_lvl_w)
	);

	// ------------------------------------------------------------
	// Clock output
	// ------------------------------------------------------------
	logic [1:0] co_cnt;
	logic       co_lvl;

	// Enable bit only acts with RC or external source
	wire co_act = port2_mode_one[`CCD_CLOCK_OUT_ENABLE_BIT] && src_rc_ext && // R14
	              osc_on; // R05

	// Three CPU clocks per half gives one sixth of the CPU rate
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			co_cnt <= 2'd0;
			co_lvl <= 1'b0;
		end else if (cpu_en_w) begin
			if (co_cnt == `CCD_CO_LAST) begin
				co_cnt <= 2'd0;
				co_lvl <= ~co_lvl; // R06
			end else begin
				co_cnt <= co_cnt + 2'd1;
			end
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	// Crystal holds both pins; external frees the second one
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cpu_clk_en       <= 1'b0;
			cpu_clk          <= 1'b0;
			clock_out_pin_o  <= 1'b0;
			clock_out_pin_oe <= 1'b0;
			p20_port_en      <= 1'b0;
			p21_port_en      <= 1'b0;
			exec_en          <= 1'b0;
		end else begin
			cpu_clk_en       <= cpu_en_w; // R09
			cpu_clk          <= cpu_lvl_w;
			clock_out_pin_o  <= co_act && co_lvl;
			clock_out_pin_oe <= co_act; // R04
			p20_port_en      <= !src_xtal && !co_act && // R13
			                    (src != CCD_OSC_RC || !co_act); // R03
			p21_port_en      <= !src_xtal && (src != CCD_OSC_EXT);
			exec_en          <= (next_pwr == CCD_RUN);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_div_reset_zero: assert property ( // R10
		$past(sys_rst) |-> cpu_clock_divider == 8'h00)
		else $error("divider not zero after reset");

	a_div_write_any: assert property ( // R12
		div_wr |=> cpu_clock_divider == $past(div_wdata))
		else $error("divider write lost");

	a_halve_zero: assert property ( // R08
		(cpu_clock_divider == 8'h00 && halve) |-> half_len == 10'd1)
		else $error("halving ratio wrong");

	a_ratio_n: assert property ( // R11
		(cpu_clock_divider != 8'h00 && !halve) |->
		half_len == {2'b00, cpu_clock_divider} + 10'd1)
		else $error("divide ratio wrong");

	a_xtal_pins_off: assert property ( // R13
		src_xtal |=> !p20_port_en && !p21_port_en)
		else $error("crystal pin left as port");

	a_ext_pin_free: assert property ( // R03
		(src == CCD_OSC_EXT && !co_act) |=> p20_port_en)
		else $error("second pin not released");

	a_clkout_source: assert property ( // R04
		clock_out_pin_oe |-> src_rc_ext)
		else $error("clock out with crystal");

	a_clkout_enbit: assert property ( // R14
		clock_out_pin_oe |-> $past(port2_mode_one[`CCD_CLOCK_OUT_ENABLE_BIT]))
		else $error("clock out without enable bit");

	a_clkout_sixth: assert property ( // R06
		(co_lvl != $past(co_lvl)) |->
		$past(cpu_en_w) && $past(co_cnt) == 2'd2)
		else $error("clock out not one sixth");

	a_warm_count: assert property ( // R15
		(pwr == CCD_WARM && next_pwr == CCD_RUN) |->
		warm_cnt == warm_need - 11'd1 ##1 exec_en)
		else $error("warm count length wrong");

	a_stop_no_clk: assert property ( // R05
		pwr == CCD_STOP |=> !cpu_en_w)
		else $error("clock runs in power-down");

endmodule : ccd_top

`default_nettype wire
